// *** logic/tpc_top.v ***
// sixteen-bit reload timer with capture, plus eight-bit capture timer
`timescale 1ns/1ps
`include "tpc_consts.vh"
module tpc_top (
   input  wire        clk_sys,
   input  wire        sys_rst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        capture_pin,
   input  wire        t8_ext_clk,
   output reg         t16_toggle_out,
   output reg         capture_pin_interrupt,
   output reg         t8_irq
);
   // register index to byte address; every register is one aligned word
   function [31:0] tpc_byte_addr;
      input [7:0] idx;
      begin
         tpc_byte_addr = {22'h000000, idx, 2'b00};
      end
   endfunction

   // byte-wide register placed in the low lane of the read word
   function [31:0] tpc_lane;
      input [7:0] b;
      begin
         tpc_lane = {24'h000000, b};
      end
   endfunction

   reg  [15:0] t16_cnt_r;
   reg  [15:0] reload_r;
   reg  [9:0]  ctrl_r;
   reg  [7:0]  t8_psc_r;
   reg         div2_r;
   reg         pin_d_r;
   reg         ext_d_r;
   reg         cap_run_r;
   reg         t8_flag_r;
   reg         pin_flag_r;

   reg  [31:0] rdata_nxt;
   reg         hit_nxt;

   wire        setup;
   wire        wr_lo;
   wire        wr_hi;
   wire        wr_ctrl;
   wire        wr_t8;
   wire        wr_psc;
   wire        wr_st;

   wire        fall;
   wire        rise;
   wire        cap_edge;
   wire        irq_edge;
   wire        t16_tick;
   wire        t16_go;
   wire        t16_at_top;

   wire [7:0]  t8_count;
   wire        t8_wrap;
   wire        ext_rise;
   wire        t8_flag_clr;
   wire        pin_flag_clr;

   // answer in the access cycle; pready is registered from setup
   assign setup   = psel && !penable;
   assign wr_lo   = psel && penable && pready && pwrite &&
                    paddr == tpc_byte_addr(`TPC_IDX_T16_LOW);
   assign wr_hi   = psel && penable && pready && pwrite &&
                    paddr == tpc_byte_addr(`TPC_IDX_T16_HIGH);
   assign wr_ctrl = psel && penable && pready && pwrite &&
                    paddr == tpc_byte_addr(`TPC_IDX_CTRL);
   assign wr_t8   = psel && penable && pready && pwrite &&
                    paddr == tpc_byte_addr(`TPC_IDX_T8);
   assign wr_psc  = psel && penable && pready && pwrite &&
                    paddr == tpc_byte_addr(`TPC_IDX_T8_PSC);
   assign wr_st   = psel && penable && pready && pwrite &&
                    paddr == tpc_byte_addr(`TPC_IDX_STATUS);

   assign fall     = pin_d_r && !capture_pin;
   assign rise     = !pin_d_r && capture_pin;
   assign cap_edge = ctrl_r[`TPC_CTRL_POLARITY] ? rise : fall;
   assign irq_edge = ctrl_r[`TPC_CTRL_IRQ_EDGE] ? rise : fall;
   // odd tick when half rate selected; full rate ticks every cycle
   assign t16_tick = ctrl_r[`TPC_CTRL_CLK_SEL] ? div2_r : 1'b1;
   assign t16_go   = t16_tick && !ctrl_r[`TPC_CTRL_STOP] &&
                     (!ctrl_r[`TPC_CTRL_T16_CAP] || cap_run_r);
   assign t16_at_top = t16_cnt_r == 16'hffff;

   assign ext_rise     = t8_ext_clk && !ext_d_r;
   assign t8_flag_clr  = wr_st && pwdata[`TPC_ST_T8_FLAG];
   assign pin_flag_clr = wr_st && pwdata[`TPC_ST_PIN_FLAG];

   // instruction-cycle enable: every second system clock
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         div2_r <= 1'b0;
      end else begin
         div2_r <= !div2_r;
      end
   end

   // pin sample idles high so reset does not fake a rising edge on a high pin
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pin_d_r <= 1'b1;
      end else begin
         pin_d_r <= capture_pin;
      end
   end

   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         ext_d_r <= 1'b0;
      end else begin
         ext_d_r <= t8_ext_clk;
      end
   end

   // control word; its reset value keeps the counter cleared
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_r <= `TPC_CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_r <= pwdata[9:0];
      end
   end

   // writes reach only the reload register, never the live count
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         reload_r <= 16'h0000;
      end else begin
         if (wr_lo)
            reload_r[7:0] <= pwdata[7:0];
         if (wr_hi)
            reload_r[15:8] <= pwdata[7:0];
      end
   end

   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         t8_psc_r <= 8'h00;
      end else if (wr_psc) begin
         t8_psc_r <= pwdata[7:0];
      end
   end

   // capture run state: each active edge flips between start and hold
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         cap_run_r <= 1'b0;
      end else if (ctrl_r[`TPC_CTRL_CLEAR]) begin
         cap_run_r <= 1'b0;                                       // wait for first edge
      end else if (cap_edge) begin
         cap_run_r <= !cap_run_r;
      end
   end

   // 16-bit counter and toggle output
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         t16_cnt_r      <= 16'h0000;
         t16_toggle_out <= 1'b0;
      end else if (ctrl_r[`TPC_CTRL_CLEAR]) begin
         t16_cnt_r <= 16'h0000;
      end else if (t16_go) begin
         if (t16_at_top) begin
            t16_cnt_r      <= reload_r;
            t16_toggle_out <= !t16_toggle_out;
         end else begin
            t16_cnt_r <= t16_cnt_r + 16'h0001;
         end
      end
   end

   tpc_t8 u_t8 (
      .clk_sys    (clk_sys),
      .sys_rst    (sys_rst),
      .instr_tick (div2_r),
      .ext_tick   (ext_rise),
      .src_sel    (ctrl_r[`TPC_CTRL_T8_SRC]),
      .stop       (ctrl_r[`TPC_CTRL_T8_STOP]),
      .cap_en     (ctrl_r[`TPC_CTRL_T8_CAP]),
      .polarity   (ctrl_r[`TPC_CTRL_POLARITY]),
      .pin_lvl    (capture_pin),
      .psc_div    (t8_psc_r),
      .wr_cnt     (wr_t8),
      .wr_psc     (wr_psc),
      .wr_data    (pwdata[7:0]),
      .count_r    (t8_count),
      .wrap_r     (t8_wrap)
   );

   // sticky flags: set beats a write-one clear in the same cycle
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         t8_flag_r <= 1'b0;
      end else if (t8_wrap) begin
         t8_flag_r <= 1'b1;
      end else if (t8_flag_clr) begin
         t8_flag_r <= 1'b0;
      end
   end

   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pin_flag_r <= 1'b0;
      end else if (irq_edge) begin
         pin_flag_r <= 1'b1;
      end else if (pin_flag_clr) begin
         pin_flag_r <= 1'b0;
      end
   end

   // request lines follow the flags, one cycle late at most
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         t8_irq <= 1'b0;
      end else begin
         t8_irq <= (t8_wrap || t8_flag_r) && ctrl_r[`TPC_CTRL_T8_IE];
      end
   end

   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         capture_pin_interrupt <= 1'b0;
      end else begin
         capture_pin_interrupt <= irq_edge || pin_flag_r;
      end
   end

   always @* begin
      hit_nxt   = 1'b1;
      rdata_nxt = 32'h00000000;
      case (paddr)
         tpc_byte_addr(`TPC_IDX_T16_LOW):  rdata_nxt = tpc_lane(t16_cnt_r[7:0]);
         tpc_byte_addr(`TPC_IDX_T16_HIGH): rdata_nxt = tpc_lane(t16_cnt_r[15:8]);
         tpc_byte_addr(`TPC_IDX_CTRL):     rdata_nxt = {22'h000000, ctrl_r};
         tpc_byte_addr(`TPC_IDX_T8):       rdata_nxt = tpc_lane(t8_count);
         tpc_byte_addr(`TPC_IDX_T8_PSC):   rdata_nxt = tpc_lane(t8_psc_r);
         tpc_byte_addr(`TPC_IDX_STATUS):   rdata_nxt = {28'h0000000, t16_toggle_out,
                                                        cap_run_r, pin_flag_r, t8_flag_r};
         default:                          hit_nxt   = 1'b0;
      endcase
   end

   // answer in the cycle after setup, never later
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pready <= 1'b0;
      end else begin
         pready <= setup;
      end
   end

   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= setup && !hit_nxt;
      end
   end

   // read data captured at setup; counter value is the one at setup time
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         prdata <= 32'h00000000;
      end else if (setup && !pwrite) begin
         prdata <= rdata_nxt;
      end
   end
endmodule // tpc_top

// *** logic/tpc_consts.vh ***
// constants for the timer pair capture block
`ifndef TPC_CONSTS_VH
`define TPC_CONSTS_VH
`define TPC_ADDR_T16_LOW      32'h0000000a
`define TPC_ADDR_T16_HIGH     32'h0000000b
`define TPC_IDX_T16_LOW       8'h0a
`define TPC_IDX_T16_HIGH      8'h0b
`define TPC_IDX_CTRL          8'h10
`define TPC_IDX_T8            8'h11
`define TPC_IDX_T8_PSC        8'h12
`define TPC_IDX_STATUS        8'h13
`define TPC_CTRL_CLK_SEL      0
`define TPC_CTRL_CLEAR        1
`define TPC_CTRL_STOP         2
`define TPC_CTRL_T16_CAP      3
`define TPC_CTRL_T8_CAP       4
`define TPC_CTRL_POLARITY     5
`define TPC_CTRL_T8_STOP      6
`define TPC_CTRL_T8_SRC       7
`define TPC_CTRL_IRQ_EDGE     8
`define TPC_CTRL_T8_IE        9
`define TPC_CTRL_RESET        10'h002
`define TPC_ST_T8_FLAG        0
`define TPC_ST_PIN_FLAG       1
`define TPC_ST_T16_RUN        2
`define TPC_ST_TOGGLE         3
`endif

// *** logic/tpc_t8.v ***
// eight-bit timer with prescaler and capture gating
`timescale 1ns/1ps
module tpc_t8 (
   input  wire       clk_sys,
   input  wire       sys_rst,
   input  wire       instr_tick,
   input  wire       ext_tick,
   input  wire       src_sel,
   input  wire       stop,
   input  wire       cap_en,
   input  wire       polarity,
   input  wire       pin_lvl,
   input  wire [7:0] psc_div,
   input  wire       wr_cnt,
   input  wire       wr_psc,
   input  wire [7:0] wr_data,
   output reg  [7:0] count_r,
   output reg        wrap_r
);
   reg  [7:0] psc_r;
   wire       gate_ok;
   wire       tick;
   assign gate_ok = !cap_en || (pin_lvl ^ polarity);
   assign tick    = src_sel ? ext_tick : instr_tick;
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         count_r <= 8'h00;
         psc_r   <= 8'h00;
         wrap_r  <= 1'b0;
      end else begin
         wrap_r <= 1'b0;
         if (wr_cnt) begin
            count_r <= wr_data;
            psc_r   <= 8'h00;
         end else if (wr_psc) begin
            psc_r <= 8'h00;
         end else if (!stop && gate_ok && tick) begin             // psc kept when gated
            if (psc_r >= psc_div) begin
               psc_r   <= 8'h00;
               count_r <= count_r + 8'h01;
               if (count_r == 8'hff)
                  wrap_r <= 1'b1;
            end else begin
               psc_r <= psc_r + 8'h01;
            end
         end
      end
   end
endmodule // tpc_t8

// *** verif/tpc_checker_assertions.sv ***
// concurrent port checks for the timer pair capture block
`timescale 1ns/1ps
module tpc_checker (
   input logic        clk_sys,
   input logic        sys_rst,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [31:0] paddr,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic        pready,
   input logic        pslverr,
   input logic        capture_pin,
   input logic        t8_ext_clk,
   input logic        t16_toggle_out,
   input logic        capture_pin_interrupt,
   input logic        t8_irq
);
   // shadow of the control word, updated at the same edge as the design's
   logic [9:0] ctrl_r;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst)
         ctrl_r <= 10'h002;
      else if (psel && penable && pready && pwrite && paddr == 32'h00000040)
         ctrl_r <= pwdata[9:0];
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   ready_after_setup_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   ready_one_cycle_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   ready_in_access_a: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   error_with_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   unmapped_reads_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   pin_fall_flag_a: assert property (!ctrl_r[8] && $fell(capture_pin) |-> ##[1:3] capture_pin_interrupt)
      else $error("no pin flag after falling edge");
   clear_holds_toggle_a: assert property (ctrl_r[1] && $past(ctrl_r[1]) |=> $stable(t16_toggle_out))
      else $error("toggle moved while cleared");
   t8_irq_masked_a: assert property (!ctrl_r[9] && $past(!ctrl_r[9]) |-> !t8_irq)
      else $error("irq while disabled");
endmodule // tpc_checker
bind tpc_top tpc_checker tpc_checker_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .capture_pin(capture_pin), .t8_ext_clk(t8_ext_clk),
   .t16_toggle_out(t16_toggle_out), .capture_pin_interrupt(capture_pin_interrupt),
   .t8_irq(t8_irq));

// *** verif/tpc_pulse_src.sv ***
// external pulse source on the capture pin
`timescale 1ns/1ps
module tpc_pulse_src #(parameter int LOW_CYC = 20, HIGH_CYC = 30, FALLS = 2) (
   input  wire logic clk_sys,
   input  wire logic go,
   output logic      capture_pin
);
   // idles high; stays low after the last fall so no extra edge restarts the timer
   initial begin
      capture_pin = 1'b1;
      wait (go);
      for (int n = 0; n < FALLS; n++) begin
         @(posedge clk_sys);
         capture_pin <= 1'b0;
         if (n == FALLS - 1)
            break;
         repeat (LOW_CYC) @(posedge clk_sys);
         capture_pin <= 1'b1;
         repeat (HIGH_CYC - 1) @(posedge clk_sys);
      end
   end
endmodule // tpc_pulse_src

// *** verif/tpc_top_test.sv ***
// self-checking bench for the timer pair capture block
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value %s exp %h got %h", n, e, g); end end
module tpc_top_test;
   logic        clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, go = 0, er, tg;
   logic [31:0] paddr = 0, pwdata = 0, prdata, rd, lo;
   logic        pready, pslverr, capture_pin, t16_toggle_out, capture_pin_interrupt, t8_irq;
   int          mismatches = 0, comparisons = 0, cycles = 0, n;
   always #5 clk_sys = ~clk_sys;
   tpc_top tpc_top_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .capture_pin(capture_pin), .t8_ext_clk(1'b0),
      .t16_toggle_out(t16_toggle_out), .capture_pin_interrupt(capture_pin_interrupt),
      .t8_irq(t8_irq));
   tpc_pulse_src tpc_pulse_src_inst (.clk_sys(clk_sys), .go(go), .capture_pin(capture_pin));
   task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_pin_irq();
      n = 0;
      while (capture_pin_interrupt !== 1'b1 && n < 200) begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= 200)
         mismatches++;
   endtask
   task automatic wait_toggle(input int lim);
      tg = t16_toggle_out;
      n = 0;
      while (t16_toggle_out === tg && n < lim) begin
         @(posedge clk_sys);
         n++;
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // ceiling covers one full 16-bit roll from zero plus the capture run
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 90000) begin
         mismatches++;
         report_and_stop();
      end
   end
   initial begin
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b0;
      acc(0, 32'h40, 0); `CHK("ctrl reset", 32'h2, rd)
      acc(0, 32'h80, 0); `CHK("unmapped error", 1'b1, er)
      acc(1, 32'h28, 32'hf0);
      acc(1, 32'h2c, 32'hff);
      acc(0, 32'h28, 0); `CHK("count held at zero", 32'h0, rd)
      acc(1, 32'h40, 0);
      n = 0;
      while (t16_toggle_out !== 1'b1 && n < 70000) begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= 70000)
         mismatches++;
      n = 0;
      while (t16_toggle_out !== 1'b0 && n < 40) begin
         @(posedge clk_sys);
         n++;
      end
      `CHK("toggle spacing", 16, n)
      acc(0, 32'h2c, 0); `CHK("high byte after reload", 32'hff, rd)
      acc(1, 32'h40, 32'h4);
      acc(0, 32'h28, 0);
      lo = rd;
      acc(0, 32'h28, 0); `CHK("stopped count", lo, rd)
      acc(1, 32'h40, 32'h1);
      wait_toggle(100);
      wait_toggle(100);
      `CHK("half rate spacing", 32, n)
      // measurement sequence: t8 stopped, t16 cleared, t8 zeroed
      acc(1, 32'h40, 32'h5a);
      acc(1, 32'h44, 0);
      acc(1, 32'h40, 32'h58);
      acc(0, 32'h28, 0); `CHK("idle before edge", 32'h0, rd)
      go <= 1'b1;
      wait_pin_irq(); `CHK("pin flag", 1'b1, capture_pin_interrupt)
      acc(1, 32'h4c, 32'h2);
      acc(1, 32'h40, 32'h18);
      wait_pin_irq();
      acc(1, 32'h40, 32'h5c);
      acc(0, 32'h44, 0); `CHK("high time", 1'b1, rd >= 13 && rd <= 17)
      acc(0, 32'h28, 0);
      lo = rd;
      acc(0, 32'h2c, 0);
      lo = {rd[7:0], lo[7:0]};
      `CHK("period", 1'b1, lo >= 48 && lo <= 52)
      acc(1, 32'h44, 32'hfe);
      acc(1, 32'h40, 32'h202);
      repeat (8) @(posedge clk_sys);
      `CHK("t8 irq", 1'b1, t8_irq)
      acc(0, 32'h4c, 0); `CHK("t8 flag", 1'b1, rd[0])
      report_and_stop();
   end
endmodule // tpc_top_test
